/* File: hdl/sfpv_defines.svh */
`ifndef SFPV_DEFINES_SVH
`define SFPV_DEFINES_SVH
// Register byte offsets
`define SFPV_REG_CMD 12'h000
`define SFPV_REG_WDATA 12'h004
`define SFPV_REG_RDATA 12'h008
`define SFPV_REG_STATUS 12'h00C
// Command register fields
`define SFPV_OPT_FIXPAR 8
`define SFPV_OPT_UNPROT 9
// Status register fields
`define SFPV_ST_BUSY 0
`define SFPV_ST_DONE 1
`define SFPV_ST_ERR 2
// Six-bit command codes, upper two bits sent as zero
`define SFPV_CMD_LOAD 6'h02
`define SFPV_CMD_READ 6'h04
`define SFPV_CMD_INCR 6'h06
`define SFPV_CMD_BEGIN 6'h08
`define SFPV_CMD_END 6'h0E
`define SFPV_CMD_BULK 6'h09
`define SFPV_CMD_BITS 5'h05
`define SFPV_DATA_BITS 5'h0F
// Configuration word field positions
`define SFPV_CFG_PAR 3
// Repeated erases needed to lift code protection
`define SFPV_ERASE_REPEAT 2'h2
// Timing
`define SFPV_CLK_MHZ 100
`define SFPV_HALF_CYC 8
`define SFPV_T_GAP_US 1
`define SFPV_T_ENDP_US 100
`define SFPV_T_ERA_US 10000
`endif

/* File: hdl/sfpv_pkg.sv */
`default_nettype none
package sfpv_pkg;
  typedef enum logic [2:0] {
    SFPV_IDLE = 3'b000,
    SFPV_CMD  = 3'b001,
    SFPV_GAPD = 3'b011,
    SFPV_DATA = 3'b010,
    SFPV_GAP  = 3'b110
  } sfpv_state_t;

  typedef struct packed {
    sfpv_state_t st;
    logic [5:0] cmd;
    logic [13:0] wdata;
    logic [13:0] rdata;
    logic [15:0] sh;
    logic [4:0] bit_cnt;
    logic [7:0] div;
    logic hi;
    logic [23:0] wait_cnt;
    logic [1:0] erase_left;
    logic fixpar;
    logic loaded;
    logic busy;
    logic done;
    logic err;
    logic sclk;
    logic sdo;
    logic sdoe;
    logic sync1;
    logic sync2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] low_cnt;
  } sfpv_regs_t;
endpackage : sfpv_pkg
`default_nettype wire

/* File: hdl/sfpv_host.sv */
// Implementation choices: the APB register port and the placing of the registers.
`default_nettype none
`include "sfpv_defines.svh"
// How it works
// - Each command goes out as six clock cycles, low bit first.
// - Wait at least 1 us after a load or read command before data.
// - A data frame is 16 cycles: start bit, 14 data bits, stop bit.
// - Data leaves on rising clock edges and is sampled on falling edges.
// - Data word low bit sits in the second frame cycle.
// - Leave 1 us between commands, 100 us after end programming.
// - Load is code 02 and read code 04, each followed by a frame.
// - A load must precede every begin programming command.
// - Three full bulk erases are needed to clear code protection.
// - Parity bit makes the config word odd, protect bits excluded.
module sfpv_host
  import sfpv_pkg::*;
#(
  parameter int unsigned HALF_CYC = `SFPV_HALF_CYC,
  parameter int unsigned END_CYC = `SFPV_T_ENDP_US * `SFPV_CLK_MHZ,
  parameter int unsigned ERA_CYC = `SFPV_T_ERA_US * `SFPV_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link to device
  output logic o_sclk,
  output logic o_sdata_out,
  output logic o_sdata_oe,
  input wire logic i_sdata_in
);
  localparam int unsigned GAP_CYC = `SFPV_T_GAP_US * `SFPV_CLK_MHZ;
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [23:0] GAP_M1 = 24'(GAP_CYC - 1);
  localparam logic [23:0] END_M1 = 24'(END_CYC - 1);
  localparam logic [23:0] ERA_M1 = 24'(ERA_CYC - 1);
  localparam logic [15:0] GAP_LOW = 16'(GAP_CYC);

  sfpv_regs_t r;
  sfpv_regs_t n;

  function automatic logic is_defined(input logic [5:0] c);
    is_defined = (c == `SFPV_CMD_LOAD) || (c == `SFPV_CMD_READ) ||
                 (c == `SFPV_CMD_INCR) || (c == `SFPV_CMD_BEGIN) ||
                 (c == `SFPV_CMD_END) || (c == `SFPV_CMD_BULK);
  endfunction : is_defined

  function automatic logic has_frame(input logic [5:0] c);
    has_frame = (c == `SFPV_CMD_LOAD) || (c == `SFPV_CMD_READ);
  endfunction : has_frame

  // Odd parity over bits 11 and 6..0, protect field left out
  function automatic logic [13:0] parity_fix(input logic [13:0] d);
    logic [13:0] o;
    o = d;
    o[`SFPV_CFG_PAR] = ~(d[11] ^ d[6] ^ d[5] ^ d[4] ^ d[2] ^ d[1] ^ d[0]);
    parity_fix = o;
  endfunction : parity_fix

  // Quiet time required after each command
  function automatic logic [23:0] gap_for(input logic [5:0] c);
    if (c == `SFPV_CMD_END) begin
      gap_for = END_M1;
    end else if (c == `SFPV_CMD_BULK) begin
      gap_for = ERA_M1;
    end else begin
      gap_for = GAP_M1;
    end
  endfunction : gap_for

  always_comb begin
    logic acc;
    logic commit;
    logic go;
    logic launch;
    logic [5:0] code;
    logic [13:0] word;
    acc = 1'b0;
    commit = 1'b0;
    go = 1'b0;
    launch = 1'b0;
    code = i_pwdata[5:0];
    word = 14'h0000;
    n = r;
    n.sync1 = i_sdata_in;
    n.sync2 = r.sync1;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.low_cnt = r.sclk ? 16'h0000 :
                (r.low_cnt == 16'hFFFF ? r.low_cnt : r.low_cnt + 16'h0001);

    // APB: one wait state, registered answer
    acc = i_psel & i_penable & ~r.pready;
    commit = i_psel & i_penable & r.pready;
    if (acc) begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      unique case (i_paddr)
        `SFPV_REG_CMD: n.prdata = {26'h0000000, r.cmd};
        `SFPV_REG_WDATA: n.prdata = {18'h00000, r.wdata};
        `SFPV_REG_RDATA: n.prdata = {18'h00000, r.rdata};
        `SFPV_REG_STATUS: n.prdata = {29'h00000000, r.err, r.done, r.busy};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (commit && i_pwrite && !r.pslverr) begin
      unique case (i_paddr)
        `SFPV_REG_WDATA: n.wdata = i_pwdata[13:0];
        `SFPV_REG_STATUS: begin
          if (i_pwdata[`SFPV_ST_DONE]) begin
            n.done = 1'b0;
          end
          if (i_pwdata[`SFPV_ST_ERR]) begin
            n.err = 1'b0;
          end
        end
        `SFPV_REG_CMD: go = 1'b1;
        default: ;
      endcase
    end

    // New order from software, taken only while idle
    if (go && r.st == SFPV_IDLE) begin
      if (i_pwdata[`SFPV_OPT_UNPROT]) begin
        code = `SFPV_CMD_BULK;
      end
      if (!is_defined(code)) begin
        n.err = 1'b1;
      end else if (code == `SFPV_CMD_BEGIN && !r.loaded) begin
        n.err = 1'b1;
      end else begin
        launch = 1'b1;
        n.busy = 1'b1;
        n.fixpar = i_pwdata[`SFPV_OPT_FIXPAR];
        n.erase_left = i_pwdata[`SFPV_OPT_UNPROT] ?
                       `SFPV_ERASE_REPEAT : 2'h0;
        if (code == `SFPV_CMD_LOAD) begin
          n.loaded = 1'b1;
        end else if (code == `SFPV_CMD_BEGIN) begin
          n.loaded = 1'b0;
        end
      end
    end

    unique case (r.st)
      SFPV_IDLE: ;
      SFPV_CMD, SFPV_DATA: begin
        n.div = r.div + 8'h01;
        if (r.div == HALF_M1) begin
          n.div = 8'h00;
          if (r.hi) begin
            // Falling edge: device latches, host samples a read
            n.sclk = 1'b0;
            n.hi = 1'b0;
            if (r.st == SFPV_DATA && r.cmd == `SFPV_CMD_READ &&
                r.bit_cnt != 5'h00 && r.bit_cnt != `SFPV_DATA_BITS) begin
              n.rdata = {r.sync2, r.rdata[13:1]};
            end
          end else if (r.st == SFPV_CMD && r.bit_cnt == `SFPV_CMD_BITS) begin
            // Six bits out, release the pin
            n.sdoe = 1'b0;
            n.sdo = 1'b0;
            if (has_frame(r.cmd)) begin
              n.st = SFPV_GAPD;
              n.wait_cnt = GAP_M1;
            end else begin
              n.st = SFPV_GAP;
              n.wait_cnt = gap_for(r.cmd);
            end
          end else if (r.st == SFPV_DATA &&
                       r.bit_cnt == `SFPV_DATA_BITS) begin
            n.sdoe = 1'b0;
            n.sdo = 1'b0;
            n.st = SFPV_GAP;
            n.wait_cnt = GAP_M1;
          end else begin
            // Rising edge: next bit onto the pin
            n.bit_cnt = r.bit_cnt + 5'h01;
            n.sclk = 1'b1;
            n.hi = 1'b1;
            n.sh = {1'b0, r.sh[15:1]};
            n.sdo = r.sh[1];
          end
        end
      end
      SFPV_GAPD: begin
        n.wait_cnt = r.wait_cnt - 24'h000001;
        if (r.wait_cnt == 24'h000000) begin
          n.st = SFPV_DATA;
          n.bit_cnt = 5'h00;
          n.div = 8'h00;
          n.hi = 1'b1;
          n.sclk = 1'b1;
          n.sdo = 1'b0;
          if (r.cmd == `SFPV_CMD_LOAD) begin
            word = r.fixpar ? parity_fix(r.wdata) : r.wdata;
            n.sh = {1'b0, word, 1'b0};
            n.sdoe = 1'b1;
          end else begin
            n.sh = 16'h0000;
            n.sdoe = 1'b0;
          end
        end
      end
      SFPV_GAP: begin
        n.wait_cnt = r.wait_cnt - 24'h000001;
        if (r.wait_cnt == 24'h000000) begin
          if (r.erase_left != 2'h0) begin
            n.erase_left = r.erase_left - 2'h1;
            code = `SFPV_CMD_BULK;
            launch = 1'b1;
          end else begin
            n.st = SFPV_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end
      end
      default: n.st = SFPV_IDLE;
    endcase

    // Command shifter start, first bit with the first rising edge
    if (launch) begin
      n.st = SFPV_CMD;
      n.cmd = code;
      n.sh = {10'h000, code};
      n.bit_cnt = 5'h00;
      n.div = 8'h00;
      n.hi = 1'b1;
      n.sclk = 1'b1;
      n.sdo = code[0];
      n.sdoe = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{st: SFPV_IDLE, low_cnt: 16'hFFFF, default: '0};
    end else begin
      r <= n;
    end
  end

  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_sclk = r.sclk;
  assign o_sdata_out = r.sdo;
  assign o_sdata_oe = r.sdoe;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_CMD_SIX_BITS: assert property (
    (r.st == SFPV_CMD && n.st != SFPV_CMD) |-> r.bit_cnt == 5'h05)
    else $error("command did not carry six bits");

  AST_DATA_DELAY: assert property (
    ($rose(o_sclk) && r.st == SFPV_DATA && r.bit_cnt == 5'h00)
    |-> $past(r.low_cnt) >= GAP_LOW)
    else $error("data frame started too soon after command");

  AST_FRAME_16: assert property (
    (r.st == SFPV_DATA && n.st != SFPV_DATA) |-> r.bit_cnt == 5'h0F)
    else $error("data frame not sixteen cycles");

  AST_DRIVE_ON_RISE: assert property (
    $changed(o_sdata_out) |-> $rose(o_sclk) || !o_sdata_oe)
    else $error("data changed away from a rising clock edge");

  AST_SAMPLE_ON_FALL: assert property (
    $changed(r.rdata) |-> $fell(o_sclk) && r.cmd == `SFPV_CMD_READ)
    else $error("read bit taken away from a falling edge");

  AST_CMD_GAP: assert property (
    ($rose(o_sclk) && r.st == SFPV_CMD && r.bit_cnt == 5'h00)
    |-> $past(r.low_cnt) >= GAP_LOW)
    else $error("commands too close together");

  AST_READ_RELEASED: assert property (
    (r.st == SFPV_DATA && r.cmd == `SFPV_CMD_READ) |-> !o_sdata_oe)
    else $error("host drives the pin during a read frame");

  AST_LOAD_FIRST: assert property (
    (r.st == SFPV_IDLE && n.st == SFPV_CMD && n.cmd == `SFPV_CMD_BEGIN)
    |-> r.loaded)
    else $error("begin programming without prior load");

  AST_ERASE_REPEAT: assert property (
    (r.st == SFPV_GAP && r.wait_cnt == 24'h000000 && r.erase_left != 2'h0)
    |=> r.st == SFPV_CMD && r.cmd == `SFPV_CMD_BULK && o_sclk)
    else $error("repeated bulk erase not issued");

  AST_ODD_PARITY: assert property (
    ($rose(r.st == SFPV_DATA) && r.cmd == `SFPV_CMD_LOAD && r.fixpar)
    |-> ^{r.sh[12], r.sh[7:1]})
    else $error("configuration word parity not odd");
endmodule : sfpv_host
`default_nettype wire

/* File: tb/sfpv_dev_model.sv */
`default_nettype none
module sfpv_dev_model (
  // Link from host
  input wire logic i_clk,
  input wire logic i_entry_n,
  input wire logic i_sclk,
  input wire logic i_data,
  // Device drive, noise when released
  output logic o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] mem [0:2047];
  logic [11:0] cfg = 12'hFFF;
  logic [10:0] pc = '0;
  logic sel = 1'b1;
  logic [5:0] cmd;
  logic [13:0] sh;
  logic [13:0] rw;
  logic [4:0] n = '0;
  logic [1:0] fr = '0;
  logic drv = 1'b0;
  logic dbit;
  logic noise = 1'b0;
  int lo;
  int hi;
  always @(posedge i_clk) noise <= ~noise;
  assign o_data = (drv && i_entry_n) ? dbit : noise;
  always @(negedge i_sclk or negedge i_entry_n) begin
    if (!i_entry_n) begin
      pc = '0;
      sel = 1'b1;
      n = '0;
      fr = '0;
    end else if (fr == 2'd0) begin
      cmd = {i_data, cmd[5:1]};
      n = n + 5'd1;
      if (n == 5'd6) begin
        n = '0;
        case (cmd[3:0])
          4'h2: fr = 2'd1;
          4'h4: fr = 2'd2;
          4'h6: if (sel) sel = 1'b0; else pc = pc + 11'd1;
          4'h8: if (sel) cfg = sh[11:0]; else mem[pc] = sh[11:0];
          4'hE: ;
          4'h9: begin
            lo = 0;
            hi = 0;
            if (sel || pc < 11'h600) begin
              hi = cfg[6] ? 'h600 : 'h640;
              cfg = 12'hFFF;
            end else if (pc < 11'h640) begin
              lo = 'h600;
              hi = cfg[6] ? 'h640 : 'h600;
            end else if (pc < 11'h648) begin
              lo = 'h640;
              hi = 'h648;
            end
            for (int i = lo; i < hi; i++) mem[i] = 12'hFFF;
          end
          default: ;
        endcase
      end
    end else begin
      n = n + 5'd1;
      if (fr == 2'd1 && n >= 5'd2 && n <= 5'd15) sh = {i_data, sh[13:1]};
      if (n == 5'd16) begin
        n = '0;
        fr = '0;
      end
    end
  end
  always @(posedge i_sclk) begin
    drv = fr == 2'd2 && n >= 5'd1 && n <= 5'd14;
    if (fr == 2'd2) begin
      if (n == 5'd1) begin
        if (sel) rw = {2'b11, cfg | 12'h800};
        else if (cfg[10:7] == 4'hB || cfg[10:7] == 4'hF || pc > 11'h5FE)
          rw = {2'b11, mem[pc]};
        else rw = 14'h3000;
      end
      dbit = rw[0];
      if (n >= 5'd1) rw = rw >> 1;
    end
  end
endmodule : sfpv_dev_model
`default_nettype wire

/* File: tb/serial_flash_program_verify_port_test.sv */
`default_nettype none
`include "sfpv_defines.svh"
module serial_flash_program_verify_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwr, pready, perr, pslverr;
  logic sclk, sdo, sdoe, dev, sin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] w;
  int n_mismatch = 0;
  int tests_run = 0;
  assign sin = sdoe ? sdo : dev;
  sfpv_host #(.END_CYC(200), .ERA_CYC(300)) uut (.i_clk(clk),
    .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_sclk(sclk),
    .o_sdata_out(sdo), .o_sdata_oe(sdoe), .i_sdata_in(sin));
  sfpv_dev_model dm (.i_clk(clk), .i_entry_n(rst_n), .i_sclk(sclk),
    .i_data(sin), .o_data(dev));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string s, input logic [31:0] e);
    tests_run++;
    if (q !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, q);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic cmd(input logic [31:0] c);
    int k;
    k = 0;
    apb(1'b1, `SFPV_REG_CMD, c);
    do begin
      apb(1'b0, `SFPV_REG_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 2000);
    if (q[0] !== 1'b0) begin
      n_mismatch++;
      $display("BAD busy exp 0 got %b", q[0]);
      final_report();
    end
  endtask : cmd
  task automatic readw(input string s, input logic [31:0] e);
    cmd(32'h4);
    apb(1'b0, `SFPV_REG_RDATA, 32'h0);
    chk(s, e);
  endtask : readw
  task automatic prog(input logic [11:0] d, input logic [31:0] opt);
    apb(1'b1, `SFPV_REG_WDATA, {18'h0, 2'($urandom_range(3, 0)), d});
    cmd(32'h2 | opt);
    cmd(32'h8);
    cmd(32'hE);
  endtask : prog
  task automatic entry();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : entry
  function automatic logic [11:0] par_fix(input logic [11:0] d);
    par_fix = d;
    par_fix[3] = ~^{d[11], d[6:4], d[2:0]};
  endfunction : par_fix
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {rst_n, psel, penable, pwr, paddr, pwdata} <= '0;
    void'($urandom(32'hE5F46A1C));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    readw("cfg_erased", 32'h3FFF);
    for (int i = 0; i < 5; i++) begin
      w = (i == 0) ? 12'hFFF : 12'($urandom);
      cmd(32'h6);
      chk("status_done", 32'h2);
      prog(w, 32'h0);
      readw("word", {18'h0, 2'b11, w});
    end
    $display("test program/read done");
    apb(1'b1, `SFPV_REG_STATUS, 32'h6);
    cmd(32'h8);
    chk("begin_no_load_err", 32'h4);
    apb(1'b1, `SFPV_REG_STATUS, 32'h6);
    apb(1'b0, `SFPV_REG_STATUS, 32'h0);
    chk("err_clear", 32'h0);
    cmd(32'h3F);
    chk("undef_err", 32'h4);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0);
    q = {31'h0, perr};
    chk("slverr", 32'h1);
    $display("test refusals done");
    entry();
    w = {1'b1, 4'b0010, 7'($urandom)};
    prog(w, 32'h100);
    readw("cfg_prot", {18'h0, 2'b11, par_fix(w)});
    cmd(32'h6);
    readw("protected", 32'h3000);
    cmd(32'h200);
    readw("unprot_erased", 32'h3FFF);
    entry();
    readw("cfg_after_erase", 32'h3FFF);
    $display("test protection done");
    final_report();
  end
endmodule : serial_flash_program_verify_port_test
`default_nettype wire
